// *** rtl/rss_map.svh ***
// Register offsets, reset values, function codes and timing figures of the run/stop sequencer.
`ifndef RSS_MAP_SVH
`define RSS_MAP_SVH

`define RSS_CLK_MHZ      200
`define RSS_KHZ_PER_MHZ  1000
`define RSS_RUN_HOLD_MS  16'd50

`define RSS_A_CTRL   4'h0
`define RSS_A_SEL0   4'h1
`define RSS_A_SEL1   4'h2
`define RSS_A_TIME0  4'h3
`define RSS_A_TIME1  4'h4
`define RSS_A_LEVEL  4'h5
`define RSS_A_KEYS   4'h6
`define RSS_A_STAT   4'h7

`define RSS_CTRL_RST   32'h0000_0003
`define RSS_SEL0_RST   32'h0403_050e
`define RSS_SEL1_RST   32'h0000_0006
`define RSS_TIME0_RST  32'h01f4_01f4
`define RSS_TIME1_RST  32'h0258_2710
`define RSS_LEVEL_RST  32'h0032_0005

`define RSS_KEY_RUN   0
`define RSS_KEY_STOP  1
`define RSS_KEY_REV   2
`define RSS_STAT_REJ  7

`define RSS_FN_3WIRE  7'h00
`define RSS_FN_MS1    7'h03
`define RSS_FN_MS2    7'h04
`define RSS_FN_MS3    7'h05
`define RSS_FN_JOG    7'h06
`define RSS_FN_MS4    7'h20
`define RSS_FN_JOG2   7'h45
`define RSS_AIN2_AUX  5'h02
`define RSS_DIR_PIN   2

`endif

// *** rtl/rss_ms_timer.sv ***
// Millisecond down-timer with a restartable prescaler and a one-cycle done pulse.
`timescale 1ns/100ps
module rss_ms_timer
    import rss_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = 200000
)(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        load,
    input  wire logic [15:0] ms,
    output logic             busy,
    output logic             done
);
    typedef struct packed {
        logic [17:0] pre;
        logic [15:0] ms;
        logic        busy;
        logic        done;
    } rss_tmr_st_t;

    rss_tmr_st_t s_reg, s_next;

    always_comb begin
        s_next      = s_reg;
        s_next.done = 1'b0;
        if (load) begin
            // Restarting the prescaler makes each loaded millisecond a full one.
            s_next.pre  = '0;
            s_next.ms   = ms;
            s_next.busy = (ms != 16'h0000);
            s_next.done = (ms == 16'h0000);
        end else if (s_reg.busy) begin
            if (s_reg.pre == 18'(CYC_PER_MS - 1)) begin
                s_next.pre = '0;
                s_next.ms  = s_reg.ms - 16'h0001;
                if (s_reg.ms == 16'h0001) begin
                    s_next.busy = 1'b0;
                    s_next.done = 1'b1;
                end
            end else begin
                s_next.pre = s_reg.pre + 18'h00001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign busy = s_reg.busy;
    assign done = s_reg.done;
endmodule

// *** rtl/rss_pkg.sv ***
// Types shared by the run/stop sequencer modules.
package rss_pkg;

    typedef enum logic [1:0] {RSS_STOP_RAMP, RSS_STOP_COAST, RSS_STOP_DCB, RSS_STOP_TCOAST} rss_stop_t;
    typedef enum logic [1:0] {RSS_SRC_PRESET, RSS_SRC_AIN1, RSS_SRC_AIN2, RSS_SRC_JOG} rss_src_t;
    typedef enum logic [2:0] {RSS_IDLE, RSS_RUN, RSS_RAMP, RSS_ZSPD, RSS_DCB, RSS_BBLK,
                              RSS_TCOAST} rss_state_t;

    typedef struct packed {
        logic [16:0] rsvd;
        logic [4:0]  analog_in_two_function_select;
        logic [1:0]  decel_sel;
        logic        closed_loop;
        logic        initialization_select;
        logic [1:0]  zero_speed_operation_select;
        rss_stop_t   stop_method_select;
        logic        freq_ref_source_select;
        logic        run_source_select;
    } rss_ctrl_t;

    typedef struct packed {
        logic [15:0] hi;
        logic [15:0] lo;
    } rss_pair_t;

    typedef struct packed {
        logic [4:0] multi;
        logic       rev;
        logic       fwd;
    } rss_term_t;

endpackage

// *** rtl/rss_sequencer.sv ***
// Run command source selection, terminal decoding and stop sequencing for a motor drive.
`timescale 1ns/100ps
`include "rss_map.svh"
module rss_sequencer
    import rss_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = `RSS_CLK_MHZ * `RSS_KHZ_PER_MHZ
)(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata,
    input  wire logic        forward_run_input,
    input  wire logic        reverse_run_input,
    input  wire logic [4:0]  multi_inputs,
    input  wire logic [15:0] output_freq,
    output logic             run_active,
    output logic             dir_reverse,
    output logic             gate_on,
    output logic             decel_active,
    output logic [1:0]       decel_time_sel,
    output logic             dc_inject,
    output logic [6:0]       dc_inject_current,
    output logic             zero_speed_ctrl,
    output logic             run_lockout,
    output rss_src_t         speed_source,
    output logic [4:0]       preset_index,
    output logic             setting_conflict_error
);
    typedef struct packed {
        rss_ctrl_t       ctrl;
        logic [4:0][6:0] sel;
        rss_pair_t       time0;
        rss_pair_t       time1;
        rss_pair_t       level;
        logic            key_run;
        logic            key_rev;
        rss_state_t      st;
        logic            run_latch;
        logic            fwd_q;
        logic            hold_ok;
        logic            reject;
        logic [15:0]     fstop;
        logic            run_active;
        logic            dir_reverse;
        logic            gate_on;
        logic            decel_active;
        logic            dc_inject;
        logic            zero_speed_ctrl;
        logic            lockout;
        logic            conflict;
        rss_src_t        src;
        logic [4:0]      preset_idx;
        logic [31:0]     rdata;
    } rss_seq_st_t;

    rss_seq_st_t s_reg, s_next;
    rss_term_t   term_raw, t;
    rss_ctrl_t   ctrl_w;
    logic        three_wire, cmd_run, cmd_rev, jog2_bad, below_zero;
    logic        tmr_load, tmr_done, hold_load, hold_done;
    logic [15:0] tmr_ms;
    logic [3:0]  step;

    localparam logic [31:0] SEL0_RST = `RSS_SEL0_RST;
    localparam logic [31:0] SEL1_RST = `RSS_SEL1_RST;

    function automatic logic has_fn(input logic [4:0][6:0] sel, input logic [6:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 5; i++) begin
            hit = hit | (sel[i] == code);
        end
        return hit;
    endfunction

    function automatic logic fn_in(input logic [4:0][6:0] sel, input logic [4:0] pins,
                                   input logic [6:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 5; i++) begin
            hit = hit | ((sel[i] == code) & pins[i]);
        end
        return hit;
    endfunction

    // Time scaled by the output frequency captured at the stop command.
    function automatic logic [15:0] scale_ms(input logic [15:0] tm, input logic [15:0] f,
                                             input logic [15:0] fmax);
        logic [31:0] q;
        q = (fmax == 16'h0000) ? {16'h0000, tm} : (tm * f) / {16'h0000, fmax};
        return (q[31:16] != 16'h0000) ? 16'hffff : q[15:0];
    endfunction

    assign term_raw = '{multi: multi_inputs, rev: reverse_run_input, fwd: forward_run_input};

    rss_sync u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .din   (term_raw),
        .dout  (t)
    );

    rss_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_stop_tmr (
        .clk   (clk),
        .rst_b (rst_b),
        .load  (tmr_load),
        .ms    (tmr_ms),
        .busy  (),
        .done  (tmr_done)
    );

    rss_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_hold_tmr (
        .clk   (clk),
        .rst_b (rst_b),
        .load  (hold_load),
        .ms    (`RSS_RUN_HOLD_MS),
        .busy  (),
        .done  (hold_done)
    );

    always_comb begin
        s_next    = s_reg;
        tmr_load  = 1'b0;
        tmr_ms    = 16'h0000;
        hold_load = 1'b0;
        ctrl_w    = rss_ctrl_t'(wdata);
        three_wire = s_reg.ctrl.initialization_select | has_fn(s_reg.sel, `RSS_FN_3WIRE);
        jog2_bad   = has_fn(s_reg.sel, `RSS_FN_JOG2) & ~three_wire;
        below_zero = (output_freq < s_reg.level.lo);

        // Three-wire run: only a press held without a break for the hold time latches.
        s_next.fwd_q   = t.fwd;
        hold_load      = three_wire & t.fwd & ~s_reg.fwd_q;
        s_next.hold_ok = hold_load | (t.fwd & s_reg.hold_ok);
        if (hold_done && t.fwd && s_reg.hold_ok && !s_reg.lockout) begin
            s_next.run_latch = 1'b1;
        end
        if (!t.rev || !three_wire) begin
            s_next.run_latch = 1'b0;
        end

        if (s_reg.ctrl.run_source_select) begin
            if (three_wire) begin
                cmd_run = s_reg.run_latch;
                cmd_rev = has_fn(s_reg.sel, `RSS_FN_3WIRE) ?
                          fn_in(s_reg.sel, t.multi, `RSS_FN_3WIRE) :
                          t.multi[`RSS_DIR_PIN];
            end else begin
                // Both inputs on together count as a stop.
                cmd_run = t.fwd ^ t.rev;
                cmd_rev = t.rev;
            end
        end else begin
            cmd_run = s_reg.key_run;
            cmd_rev = s_reg.key_rev;
        end

        // Speed source from the multi-step inputs; jog has priority.
        step = {fn_in(s_reg.sel, t.multi, `RSS_FN_MS4),
                fn_in(s_reg.sel, t.multi, `RSS_FN_MS3),
                fn_in(s_reg.sel, t.multi, `RSS_FN_MS2),
                fn_in(s_reg.sel, t.multi, `RSS_FN_MS1)};
        s_next.preset_idx = {1'b0, step} + 5'h01;
        if (fn_in(s_reg.sel, t.multi, `RSS_FN_JOG) |
            (three_wire & fn_in(s_reg.sel, t.multi, `RSS_FN_JOG2))) begin
            s_next.src = RSS_SRC_JOG;
        end else if (step == 4'h0 && s_reg.ctrl.freq_ref_source_select) begin
            s_next.src = RSS_SRC_AIN1;
        end else if (step == 4'h1 &&
                     s_reg.ctrl.analog_in_two_function_select == `RSS_AIN2_AUX) begin
            s_next.src = RSS_SRC_AIN2;
        end else begin
            s_next.src = RSS_SRC_PRESET;
        end

        unique case (s_reg.st)
            RSS_IDLE: begin
                if (cmd_run) begin
                    s_next.st = RSS_RUN;
                end
            end
            RSS_RUN: begin
                if (!cmd_run) begin
                    s_next.fstop     = output_freq;
                    s_next.run_latch = 1'b0;
                    s_next.key_run   = 1'b0;
                    unique case (s_reg.ctrl.stop_method_select)
                        RSS_STOP_RAMP: begin
                            s_next.st = RSS_RAMP;
                        end
                        RSS_STOP_COAST, RSS_STOP_DCB: begin
                            s_next.st = RSS_BBLK;
                            tmr_load  = 1'b1;
                            tmr_ms    = s_reg.time0.lo;
                        end
                        RSS_STOP_TCOAST: begin
                            s_next.st = RSS_TCOAST;
                            tmr_load  = 1'b1;
                            tmr_ms    = scale_ms(s_reg.time1.lo, output_freq, s_reg.time1.hi);
                        end
                    endcase
                end
            end
            RSS_RAMP: begin
                if (cmd_run) begin
                    s_next.st = RSS_RUN;
                end else if (below_zero) begin
                    tmr_load = 1'b1;
                    tmr_ms   = s_reg.time0.hi;
                    if (!s_reg.ctrl.closed_loop) begin
                        s_next.st = RSS_DCB;
                    end else if (s_reg.ctrl.zero_speed_operation_select == 2'h1) begin
                        s_next.st = RSS_BBLK;
                        tmr_ms    = s_reg.time0.lo;
                    end else begin
                        s_next.st = RSS_ZSPD;
                    end
                end
            end
            RSS_BBLK: begin
                // Run commands are not looked at here, which is the lockout.
                if (tmr_done) begin
                    if (s_reg.ctrl.stop_method_select == RSS_STOP_DCB &&
                        !s_reg.ctrl.closed_loop) begin
                        s_next.st = RSS_DCB;
                        tmr_load  = 1'b1;
                        tmr_ms    = scale_ms(s_reg.time0.hi, s_reg.fstop, s_reg.time1.hi);
                    end else begin
                        s_next.st = RSS_IDLE;
                    end
                end
            end
            RSS_ZSPD, RSS_DCB, RSS_TCOAST: begin
                if (tmr_done) begin
                    s_next.st = RSS_IDLE;
                end
            end
            default: begin
                s_next.st = RSS_IDLE;
            end
        endcase

        // Settings are frozen from the run command until the stop has completed.
        if (wr && s_reg.st == RSS_IDLE) begin
            unique case (addr)
                `RSS_A_CTRL: begin
                    ctrl_w.rsvd = '0;
                    if (ctrl_w.closed_loop && (ctrl_w.stop_method_select == RSS_STOP_DCB ||
                        ctrl_w.stop_method_select == RSS_STOP_TCOAST)) begin
                        // The whole word is dropped, so closed loop never meets method 2 or 3.
                        s_next.reject = 1'b1;
                    end else begin
                        s_next.ctrl = ctrl_w;
                    end
                end
                `RSS_A_SEL0: begin
                    for (int i = 0; i < 4; i++) begin
                        s_next.sel[i] = wdata[8*i +: 7];
                    end
                end
                `RSS_A_SEL1:  s_next.sel[4] = wdata[6:0];
                `RSS_A_TIME0: s_next.time0 = wdata;
                `RSS_A_TIME1: s_next.time1 = wdata;
                `RSS_A_LEVEL: s_next.level = {9'h000, wdata[22:0]};
                default: ;
            endcase
        end
        if (wr && addr == `RSS_A_KEYS) begin
            s_next.key_rev = wdata[`RSS_KEY_REV];
            if (wdata[`RSS_KEY_RUN] && !s_reg.lockout) begin
                s_next.key_run = 1'b1;
            end
            if (wdata[`RSS_KEY_STOP]) begin
                s_next.key_run = 1'b0;
            end
        end
        if (wr && addr == `RSS_A_STAT && wdata[`RSS_STAT_REJ]) begin
            s_next.reject = 1'b0;
        end

        s_next.run_active      = (s_next.st == RSS_RUN);
        s_next.dir_reverse     = (s_reg.st == RSS_RUN || s_reg.st == RSS_IDLE) ?
                                 cmd_rev : s_reg.dir_reverse;
        s_next.gate_on         = (s_next.st == RSS_RUN || s_next.st == RSS_RAMP ||
                                  s_next.st == RSS_ZSPD || s_next.st == RSS_DCB);
        s_next.decel_active    = (s_next.st == RSS_RAMP);
        s_next.dc_inject       = (s_next.st == RSS_DCB);
        s_next.zero_speed_ctrl = (s_next.st == RSS_ZSPD);
        s_next.lockout         = (s_next.st == RSS_BBLK || s_next.st == RSS_TCOAST);
        s_next.conflict        = jog2_bad | s_next.reject;

        s_next.rdata = 32'h0000_0000;
        if (rd) begin
            unique case (addr)
                `RSS_A_CTRL:  s_next.rdata = s_reg.ctrl;
                `RSS_A_SEL0:  s_next.rdata = {1'b0, s_reg.sel[3], 1'b0, s_reg.sel[2],
                                              1'b0, s_reg.sel[1], 1'b0, s_reg.sel[0]};
                `RSS_A_SEL1:  s_next.rdata = {25'h0000000, s_reg.sel[4]};
                `RSS_A_TIME0: s_next.rdata = s_reg.time0;
                `RSS_A_TIME1: s_next.rdata = s_reg.time1;
                `RSS_A_LEVEL: s_next.rdata = s_reg.level;
                `RSS_A_KEYS:  s_next.rdata = {29'h00000000, s_reg.key_rev, 1'b0, s_reg.key_run};
                `RSS_A_STAT:  s_next.rdata = {17'h00000, s_reg.src, s_reg.preset_idx,
                                              s_reg.reject, s_reg.conflict, s_reg.lockout,
                                              s_reg.dir_reverse, s_reg.run_latch, s_reg.st};
                default:      s_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg       <= '0;
            s_reg.ctrl  <= `RSS_CTRL_RST;
            s_reg.sel   <= {SEL1_RST[6:0], SEL0_RST[30:24], SEL0_RST[22:16],
                            SEL0_RST[14:8], SEL0_RST[6:0]};
            s_reg.time0 <= `RSS_TIME0_RST;
            s_reg.time1 <= `RSS_TIME1_RST;
            s_reg.level <= `RSS_LEVEL_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata                  = s_reg.rdata;
    assign run_active             = s_reg.run_active;
    assign dir_reverse            = s_reg.dir_reverse;
    assign gate_on                = s_reg.gate_on;
    assign decel_active           = s_reg.decel_active;
    assign decel_time_sel         = s_reg.ctrl.decel_sel;
    assign dc_inject              = s_reg.dc_inject;
    assign dc_inject_current      = s_reg.level.hi[6:0];
    assign zero_speed_ctrl        = s_reg.zero_speed_ctrl;
    assign run_lockout            = s_reg.lockout;
    assign speed_source           = s_reg.src;
    assign preset_index           = s_reg.preset_idx;
    assign setting_conflict_error = s_reg.conflict;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_COAST_CUTS: assert property (
        s_reg.st == RSS_RUN && !cmd_run && s_reg.ctrl.stop_method_select == RSS_STOP_COAST
        |=> !gate_on && s_reg.st == RSS_BBLK) else $error("coast stop left output on");
    AST_BBLK_LOCK: assert property (
        s_reg.st == RSS_BBLK |=> s_reg.st != RSS_RUN) else $error("run accepted in baseblock");
    AST_TCOAST_LOCK: assert property (
        s_reg.st == RSS_TCOAST |=> s_reg.st == RSS_TCOAST || s_reg.st == RSS_IDLE)
        else $error("run accepted during timed coast");
    AST_RAMP_START: assert property (
        s_reg.st == RSS_RUN && !cmd_run && s_reg.ctrl.stop_method_select == RSS_STOP_RAMP
        |=> decel_active && gate_on) else $error("ramp stop did not decelerate");
    AST_ZERO_DCB: assert property (
        s_reg.st == RSS_RAMP && !cmd_run && below_zero && !s_reg.ctrl.closed_loop
        |=> dc_inject ##1 dc_inject || s_reg.st == RSS_IDLE)
        else $error("no DC injection below zero speed level");
    AST_CLV_REJECT: assert property (
        wr && addr == `RSS_A_CTRL && s_reg.st == RSS_IDLE && ctrl_w.closed_loop &&
        wdata[3] |=> s_reg.ctrl.stop_method_select != RSS_STOP_DCB &&
        s_reg.ctrl.stop_method_select != RSS_STOP_TCOAST && setting_conflict_error)
        else $error("closed loop accepted stop method 2 or 3");
    AST_RUN_FROZEN: assert property (
        wr && s_reg.st != RSS_IDLE |=> $stable(s_reg.ctrl))
        else $error("settings changed while running");
    AST_TWO_WIRE_FWD: assert property (
        s_reg.ctrl.run_source_select && !three_wire && s_reg.st == RSS_IDLE && t.fwd && !t.rev
        |=> run_active && !dir_reverse) else $error("two-wire forward did not run");
    AST_JOG2_CONFLICT: assert property (
        jog2_bad |=> setting_conflict_error) else $error("jog two conflict not flagged");
endmodule

// *** rtl/rss_sync.sv ***
// Two-flop synchroniser for the control terminals.
`timescale 1ns/100ps
module rss_sync
    import rss_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst_b,
    input  wire rss_term_t din,
    output rss_term_t      dout
);
    typedef struct packed {
        rss_term_t meta;
        rss_term_t sync;
    } rss_sync_st_t;

    rss_sync_st_t s_reg, s_next;

    always_comb begin
        s_next      = s_reg;
        s_next.meta = din;
        s_next.sync = s_reg.meta;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign dout = s_reg.sync;
endmodule

// *** verif/rss_contacts.sv ***
// Model of the external run contacts; a closed forward contact stays closed HOLD_CYC cycles.
`timescale 1ns/100ps
module rss_contacts #(
    parameter int HOLD_CYC = 2
)(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic fwd_cmd,
    input  wire logic rev_cmd,
    output logic      fwd,
    output logic      rev
);
    int cnt;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fwd <= 1'b0;
            rev <= 1'b0;
            cnt <= 0;
        end else begin
            rev <= rev_cmd;
            if (fwd_cmd) begin
                fwd <= 1'b1;
                cnt <= HOLD_CYC;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end else begin
                fwd <= 1'b0;
            end
        end
    end
endmodule

// *** verif/rss_sequencer_tb_top.sv ***
// Self-checking testbench for the run/stop sequencer.
`timescale 1ns/100ps
module rss_sequencer_tb_top;
    logic        clk, rst_b, wr, rd, rd_d, fwd_c, rev_c, fwd, rev;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata;
    logic [4:0]  mi;
    logic [15:0] freq;
    wire [23:0]  ov;
    int          n_mismatch, check_count;
    logic [31:0] q_exp[$], q_msk[$];

    rss_contacts #(.HOLD_CYC(2)) i_sw (.clk(clk), .rst_b(rst_b), .fwd_cmd(fwd_c),
        .rev_cmd(rev_c), .fwd(fwd), .rev(rev));
    rss_sequencer #(.CYC_PER_MS(20)) i_dut (.clk(clk), .rst_b(rst_b), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .forward_run_input(fwd),
        .reverse_run_input(rev), .multi_inputs(mi), .output_freq(freq), .run_active(ov[7]),
        .dir_reverse(ov[6]), .gate_on(ov[5]), .decel_active(ov[4]), .decel_time_sel(ov[9:8]),
        .dc_inject(ov[3]), .dc_inject_current(ov[23:17]), .zero_speed_ctrl(ov[2]),
        .run_lockout(ov[1]), .speed_source(ov[11:10]), .preset_index(ov[16:12]),
        .setting_conflict_error(ov[0]));

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // The expectation is queued before the strobe so the monitor never finds it missing.
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        q_msk.push_back(m);
        q_exp.push_back(e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic check_rd(input logic [31:0] got);
        logic [31:0] m, e;
        check_count++;
        m = (q_msk.size() > 0) ? q_msk.pop_front() : 32'hffff_ffff;
        e = (q_exp.size() > 0) ? q_exp.pop_front() : 32'hxxxx_xxxx;
        if ((got & m) !== e) begin
            n_mismatch++;
            $display("Error at %0t: read %h mask %h expected %h", $time, got, m, e);
        end
    endtask
    // Level outputs are compared at the falling edge, well away from the edge that launches them.
    task automatic chk_out(input logic [23:0] m, input logic [23:0] e);
        @(negedge clk);
        check_count++;
        if ((ov & m) !== e) begin
            n_mismatch++;
            $display("Error at %0t: outputs %h mask %h expected %h", $time, ov, m, e);
        end
        @(posedge clk);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d === 1'b1) begin
            check_rd(rdata);
        end
    end

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #100000;
        n_mismatch++;
        finish_test();
    end

    initial begin
        rst_b = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        fwd_c = 1'b0;
        rev_c = 1'b0;
        mi = 5'h00;
        freq = 16'h0000;
        n_mismatch = 0;
        check_count = 0;
        void'($urandom(32'hd8c2));
        cyc(8);
        rst_b <= 1'b1;
        rd_reg(4'h0, 32'hffff_ffff, 32'h0000_0003);
        rd_reg(4'h1, 32'hffff_ffff, 32'h0403_050e);
        rd_reg(4'h9, 32'hffff_ffff, 32'h0000_0000);
        rd_reg(4'h7, 32'hffff_ffff, 32'h0000_2100);
        chk_out(24'hff_ffff, 24'h64_1400);
        $display("test reset done");
        // Short brake and baseblock times keep the stop sequences within a few dozen cycles.
        wr_reg(4'h3, {16'h0001, 16'h0002});
        freq <= 16'h0064 + 16'($urandom_range(0, 400));
        mi <= 5'($urandom);
        fwd_c <= 1'b1;
        cyc(6);
        rd_reg(4'h7, 32'h17, 32'h01);
        chk_out(24'h00_00ff, 24'h00_00a0);
        fwd_c <= 1'b0;
        cyc(8);
        rd_reg(4'h7, 32'h07, 32'h02);
        chk_out(24'h00_00ff, 24'h00_0030);
        freq <= 16'($urandom_range(0, 4));
        cyc(6);
        rd_reg(4'h7, 32'h07, 32'h04);
        chk_out(24'h00_00ff, 24'h00_0028);
        cyc(40);
        rd_reg(4'h7, 32'h07, 32'h00);
        chk_out(24'h00_00ff, 24'h00_0000);
        $display("test ramp done");
        wr_reg(4'h0, 32'h0000_0007);
        freq <= 16'h012c;
        rev_c <= 1'b1;
        cyc(6);
        rd_reg(4'h7, 32'h17, 32'h11);
        chk_out(24'h00_00ff, 24'h00_00e0);
        rev_c <= 1'b0;
        cyc(6);
        rd_reg(4'h7, 32'h27, 32'h25);
        chk_out(24'h00_00bf, 24'h00_0002);
        fwd_c <= 1'b1;
        cyc(20);
        rd_reg(4'h7, 32'h07, 32'h05);
        chk_out(24'h00_00bf, 24'h00_0002);
        cyc(40);
        rd_reg(4'h7, 32'h07, 32'h01);
        chk_out(24'h00_00ff, 24'h00_00a0);
        fwd_c <= 1'b0;
        cyc(70);
        $display("test coast done");
        wr_reg(4'h0, 32'h0000_008b);
        rd_reg(4'h7, 32'hc0, 32'hc0);
        rd_reg(4'h0, 32'h0c, 32'h04);
        wr_reg(4'h7, 32'h0000_0080);
        chk_out(24'h00_0001, 24'h00_0000);
        wr_reg(4'h2, 32'h0000_0045);
        mi <= 5'h04;
        wr_reg(4'h0, 32'h0000_0803);
        cyc(4);
        rd_reg(4'h7, 32'h6000, 32'h4000);
        chk_out(24'h01_fc01, 24'h00_2801);
        $display("test select done");
        // Three-wire: the stop contact is normally closed and run is held past the 50 ms.
        wr_reg(4'h0, 32'h0000_0043);
        rev_c <= 1'b1;
        fwd_c <= 1'b1;
        cyc(1010);
        fwd_c <= 1'b0;
        cyc(6);
        rd_reg(4'h7, 32'h5f, 32'h19);
        chk_out(24'h00_00ff, 24'h00_00e0);
        rev_c <= 1'b0;
        cyc(6);
        rd_reg(4'h7, 32'h0f, 32'h02);
        $display("test three-wire done");
        cyc(4);
        finish_test();
    end
endmodule
